/* File: shared/sut_pkg.sv */
package sut_pkg;

   // ---------------------------------------------
   // register map
   // ---------------------------------------------
   localparam logic [7:0] ADDR_KEY = 8'ha6;
   localparam logic [7:0] ADDR_CTRL = 8'ha7;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // ---------------------------------------------
   // control field positions
   // ---------------------------------------------
   localparam int PS_LSB = 5;
   localparam int PS_MSB = 7;
   localparam int BIT_IDLE_DIS = 4;
   localparam int BIT_RSTO_DIS = 3;
   localparam int BIT_SOFT = 2;
   localparam int BIT_OVF = 1;
   localparam int BIT_RUN = 0;

   // ---------------------------------------------
   // key bytes
   // ---------------------------------------------
   localparam logic [7:0] KEY_RUN_1 = 8'h1e;
   localparam logic [7:0] KEY_RUN_2 = 8'he1;
   localparam logic [7:0] KEY_SOFT_1 = 8'h5a;
   localparam logic [7:0] KEY_SOFT_2 = 8'ha5;

   // ---------------------------------------------
   // counting chain
   // ---------------------------------------------
   localparam int PRE_W = 7;
   localparam int TMR_W = 14;
   localparam int CNT_W = PRE_W + TMR_W;
   localparam int PERIOD_BASE_EXP = 14;
   localparam int TPS_W = 4;

   // ---------------------------------------------
   // types
   // ---------------------------------------------
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_RUN_HALF,
      SEQ_SOFT_HALF
   } sut_seq_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sut_sfr_req_t;

endpackage

/* File: verilog/sut_count_chain.sv */
module sut_count_chain #(
   parameter int PRE_W = 7,
   parameter int TMR_W = 14
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // control
   input wire logic clr,
   input wire logic tick,
   // state
   output logic [PRE_W+TMR_W-1:0] count
);

   logic [PRE_W-1:0] pre_r;
   logic [PRE_W-1:0] pre_nxt;
   logic [TMR_W-1:0] tmr_r;
   logic [TMR_W-1:0] tmr_nxt;

   always_comb begin
      pre_nxt = pre_r;
      tmr_nxt = tmr_r;
      if (clr) begin
         pre_nxt = '0;
         tmr_nxt = '0;
      end else if (tick) begin
         pre_nxt = pre_r + 1'b1;
         if (&pre_r) begin
            tmr_nxt = tmr_r + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pre_r <= '0;
         tmr_r <= '0;
      end else begin
         pre_r <= pre_nxt;
         tmr_r <= tmr_nxt;
      end
   end

   assign count = {tmr_r, pre_r};

endmodule

/* File: verilog/sut_watchdog.sv */
// Overview of operation
// - The timer counts system clock cycles by default.
// - Control bits 7 to 5 pick a time-out of 2 to the power of code plus 14 cycles.
// - The time-out is stretched by one plus the external system timer prescale value.
// - Counting uses a 7-bit prescaler feeding a 14-bit timer.
// - Any reset stops and disables the timer, and it never counts in power-down.
// - Reaching the time-out unfed sends an internal reset pulse to the cpu.
// - Writing 1e then e1 to the key register starts the timer and sets the running bit.
// - Reads may come between the two key bytes, but any other register write breaks the pair.
// - Any other key pattern resets at once and sets both reset-cause flags.
// - Writing 5a then a5 makes a software reset even when stopped and sets the soft flag.
// - A time-out reset sets the overflow flag, which holds until software clears it.
// - Unless reset output is disabled, a watchdog reset drives the reset pin to its polarity.
// - The running bit is read-only and shows whether the timer runs.
module sut_watchdog #(
   parameter int TPS_W = sut_pkg::TPS_W
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // register bus
   input wire sut_pkg::sut_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   // system state
   input wire logic idle_mode,
   input wire logic power_down,
   input wire logic [TPS_W-1:0] system_timer_prescale,
   input wire logic reset_pin_polarity,
   // reset outputs
   output logic cpu_reset,
   output logic rst_pin_o,
   output logic rst_pin_oe
);

   // ---------------------------------------------
   // state
   // ---------------------------------------------
   sut_pkg::sut_seq_t seq_r, seq_nxt;
   logic [7:0] ctrl_r, ctrl_nxt;
   logic [TPS_W-1:0] tps_cnt_r, tps_cnt_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic rst_r, rst_nxt;
   logic pin_o_r, pin_o_nxt;
   logic pin_oe_r, pin_oe_nxt;
   logic [sut_pkg::CNT_W-1:0] count;
   logic [sut_pkg::CNT_W-1:0] limit;
   logic [2:0] ps;
   logic key_wr, other_wr, ctrl_wr;
   logic feed, soft_go, key_err;
   logic count_en, tick, timeout, clr;

   // ---------------------------------------------
   // decode
   // ---------------------------------------------
   always_comb begin
      key_wr = 1'b0;
      other_wr = 1'b0;
      ctrl_wr = 1'b0;
      if (sfr_req.wr && sfr_req.addr == sut_pkg::ADDR_KEY) begin
         key_wr = 1'b1;
      end else if (sfr_req.wr) begin
         other_wr = 1'b1;
         ctrl_wr = (sfr_req.addr == sut_pkg::ADDR_CTRL);
      end
   end

   // ---------------------------------------------
   // key sequence
   // ---------------------------------------------
   always_comb begin
      seq_nxt = seq_r;
      feed = 1'b0;
      soft_go = 1'b0;
      key_err = 1'b0;
      case (seq_r)
         sut_pkg::SEQ_IDLE: begin
            if (key_wr) begin
               if (sfr_req.wdata == sut_pkg::KEY_RUN_1) begin
                  seq_nxt = sut_pkg::SEQ_RUN_HALF;
               end else if (sfr_req.wdata == sut_pkg::KEY_SOFT_1) begin
                  seq_nxt = sut_pkg::SEQ_SOFT_HALF;
               end else begin
                  key_err = 1'b1;
               end
            end
         end
         sut_pkg::SEQ_RUN_HALF: begin
            if (key_wr) begin
               seq_nxt = sut_pkg::SEQ_IDLE;
               feed = (sfr_req.wdata == sut_pkg::KEY_RUN_2);
               key_err = !feed;
            end else if (other_wr) begin
               seq_nxt = sut_pkg::SEQ_IDLE;
            end
         end
         sut_pkg::SEQ_SOFT_HALF: begin
            if (key_wr) begin
               seq_nxt = sut_pkg::SEQ_IDLE;
               soft_go = (sfr_req.wdata == sut_pkg::KEY_SOFT_2);
               key_err = !soft_go;
            end else if (other_wr) begin
               seq_nxt = sut_pkg::SEQ_IDLE;
            end
         end
         default: seq_nxt = sut_pkg::SEQ_IDLE;
      endcase
   end

   // ---------------------------------------------
   // counting
   // ---------------------------------------------
   assign ps = ctrl_r[sut_pkg::PS_MSB:sut_pkg::PS_LSB];

   // halt in power-down and optionally idle
   assign count_en = ctrl_r[sut_pkg::BIT_RUN] && !power_down
                     && !(idle_mode && ctrl_r[sut_pkg::BIT_IDLE_DIS]);
   // one tick per clock times prescale plus one
   assign tick = count_en && (tps_cnt_r == system_timer_prescale);
   assign limit = sut_pkg::CNT_W'((22'h1 << (5'(ps) + 5'(sut_pkg::PERIOD_BASE_EXP)))
                  - 22'h1);
   assign timeout = tick && (count == limit) && !feed;
   // feed restarts; stopped timer held clear
   assign clr = feed || !ctrl_r[sut_pkg::BIT_RUN];

   always_comb begin
      tps_cnt_nxt = tps_cnt_r;
      if (clr || tick) begin
         tps_cnt_nxt = '0;
      end else if (count_en) begin
         tps_cnt_nxt = tps_cnt_r + 1'b1;
      end
   end

   sut_count_chain #(
      .PRE_W(sut_pkg::PRE_W),
      .TMR_W(sut_pkg::TMR_W)
   ) u_chain (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .clr(clr),
      .tick(tick),
      .count(count)
   );

   // ---------------------------------------------
   // control register and reset outputs
   // ---------------------------------------------
   always_comb begin
      ctrl_nxt = ctrl_r;
      rst_nxt = 1'b0;
      if (ctrl_wr) begin
         ctrl_nxt[7:3] = sfr_req.wdata[7:3];
         // flags only clear by write; writing one keeps them
         ctrl_nxt[2:1] = ctrl_r[2:1] & sfr_req.wdata[2:1];
      end
      if (feed) begin
         ctrl_nxt[sut_pkg::BIT_RUN] = 1'b1;
      end
      if (timeout || soft_go || key_err) begin
         rst_nxt = 1'b1;
         // our own reset also stops the timer; flags survive it
         // a clear written in this cycle still reaches the flag not being set
         ctrl_nxt = {sut_pkg::CTRL_RESET[7:3], ctrl_nxt[2:1], 1'b0};
         // overflow and soft flags, set wins over clear
         ctrl_nxt[sut_pkg::BIT_OVF] = ctrl_nxt[sut_pkg::BIT_OVF] || timeout || key_err;
         ctrl_nxt[sut_pkg::BIT_SOFT] = ctrl_nxt[sut_pkg::BIT_SOFT] || soft_go || key_err;
      end
      // pin driven only when output not disabled
      pin_oe_nxt = rst_nxt && !ctrl_r[sut_pkg::BIT_RSTO_DIS];
      pin_o_nxt = reset_pin_polarity;
      // running bit read back, never written
      rdata_nxt = (sfr_req.rd && sfr_req.addr == sut_pkg::ADDR_CTRL) ? ctrl_r : 8'h00;
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         seq_r <= sut_pkg::SEQ_IDLE;
         ctrl_r <= sut_pkg::CTRL_RESET;
         tps_cnt_r <= '0;
         rdata_r <= 8'h00;
         rst_r <= 1'b0;
         pin_o_r <= 1'b0;
         pin_oe_r <= 1'b0;
      end else begin
         seq_r <= (rst_nxt ? sut_pkg::SEQ_IDLE : seq_nxt);
         ctrl_r <= ctrl_nxt;
         tps_cnt_r <= tps_cnt_nxt;
         rdata_r <= rdata_nxt;
         rst_r <= rst_nxt;
         pin_o_r <= pin_o_nxt;
         pin_oe_r <= pin_oe_nxt;
      end
   end

   assign sfr_rdata = rdata_r;
   assign cpu_reset = rst_r;
   assign rst_pin_o = pin_o_r;
   assign rst_pin_oe = pin_oe_r;

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   a_enable_sets_run: assert property (
      seq_r == sut_pkg::SEQ_RUN_HALF && key_wr && sfr_req.wdata == sut_pkg::KEY_RUN_2
      |=> ctrl_r[sut_pkg::BIT_RUN] && !cpu_reset)
      else $error("enable pair did not start timer");
   a_feed_clears_count: assert property (
      feed |=> count == '0)
      else $error("feed did not clear chain");
   a_timeout_reset: assert property (
      timeout |=> cpu_reset && ctrl_r[sut_pkg::BIT_OVF] && !ctrl_r[sut_pkg::BIT_RUN])
      else $error("time-out reset missing");
   a_soft_reset_flag: assert property (
      seq_r == sut_pkg::SEQ_SOFT_HALF && key_wr && sfr_req.wdata == sut_pkg::KEY_SOFT_2
      |=> cpu_reset && ctrl_r[sut_pkg::BIT_SOFT])
      else $error("soft reset pair failed");
   a_error_both_flags: assert property (
      key_wr && seq_r == sut_pkg::SEQ_IDLE && sfr_req.wdata != sut_pkg::KEY_RUN_1
      && sfr_req.wdata != sut_pkg::KEY_SOFT_1
      |=> cpu_reset && ctrl_r[sut_pkg::BIT_SOFT] && ctrl_r[sut_pkg::BIT_OVF])
      else $error("bad key did not reset with both flags");
   a_break_on_write: assert property (
      seq_r != sut_pkg::SEQ_IDLE && other_wr && !timeout
      |=> seq_r == sut_pkg::SEQ_IDLE && !cpu_reset)
      else $error("other write did not break pair");
   a_hold_power_down: assert property (
      power_down && !clr |=> $stable(count))
      else $error("counted in power-down");
   a_hold_idle: assert property (
      idle_mode && ctrl_r[sut_pkg::BIT_IDLE_DIS] && !clr |=> $stable(count))
      else $error("counted in idle");
   a_run_read_only: assert property (
      ctrl_wr && !feed && !timeout && !soft_go && !key_err
      |=> ctrl_r[sut_pkg::BIT_RUN] == $past(ctrl_r[sut_pkg::BIT_RUN]))
      else $error("running bit changed by write");
   a_pin_drive: assert property (
      rst_pin_oe |-> cpu_reset && !$past(ctrl_r[sut_pkg::BIT_RSTO_DIS])
      && rst_pin_o == $past(reset_pin_polarity))
      else $error("reset pin drive wrong");
   a_tick_spacing: assert property (
      tick && system_timer_prescale == 4'h1 && !clr && count_en
      ##1 count_en && !clr && system_timer_prescale == 4'h1
      |-> !tick)
      else $error("prescale stretch wrong");
   a_flag_holds: assert property (
      ctrl_r[sut_pkg::BIT_OVF] && !ctrl_wr |=> ctrl_r[sut_pkg::BIT_OVF])
      else $error("overflow flag dropped");

   c_feed: cover property (feed);
   c_timeout: cover property (timeout);
   c_soft: cover property (soft_go);
   c_error: cover property (key_err);

endmodule

/* File: verif/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ns;

   // ---------------------------------------------
   // stimulus and observed signals
   // ---------------------------------------------
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   sut_pkg::sut_sfr_req_t sfr_req = '0;
   logic [7:0] sfr_rdata;
   logic idle_mode = 1'b0;
   logic power_down = 1'b0;
   logic [3:0] system_timer_prescale = 4'h0;
   logic reset_pin_polarity = 1'b1;
   logic cpu_reset;
   logic rst_pin_o;
   logic rst_pin_oe;
   int err_total = 0;
   int total_checks = 0;
   int cycles = 0;
   int n;
   logic [7:0] v;
   logic [7:0] bad_keys [4] = '{8'h33, 8'he1, 8'ha5, 8'h00};

   sut_watchdog i_sut_watchdog (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata),
      .idle_mode(idle_mode),
      .power_down(power_down),
      .system_timer_prescale(system_timer_prescale),
      .reset_pin_polarity(reset_pin_polarity),
      .cpu_reset(cpu_reset),
      .rst_pin_o(rst_pin_o),
      .rst_pin_oe(rst_pin_oe)
   );

   // ---------------------------------------------
   // clock and hang guard
   // ---------------------------------------------
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end

   // the longest runs add up to about 88k cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 95000) begin
         err_total++;
         stop_test();
      end
   end

   // ---------------------------------------------
   // bus tasks and checks
   // ---------------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // release at the taking edge by nba so the next call may drive 1 ns later
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      sfr_req <= '0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      sfr_req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      sfr_req <= '0;
      #1;
      chk(sfr_rdata, exp);
   endtask

   // pulse is one cycle wide, pin level follows polarity throughout
   task automatic pulse(input logic [7:0] exp);
      chk({5'h00, rst_pin_o, rst_pin_oe, cpu_reset}, exp);
      @(posedge ref_clk);
      #1;
      chk({5'h00, rst_pin_o, rst_pin_oe, cpu_reset}, {5'h00, exp[2], 2'b00});
   endtask

   // window of a few cycles for the pipeline between feed and pulse
   task automatic wait_rst(input int lo, input int hi);
      n = 0;
      while (cpu_reset !== 1'b1 && n < hi + 5) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      total_checks++;
      if (n < lo || n > hi) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, n, lo);
      end
   endtask

   task automatic run(input int c);
      repeat (c) @(posedge ref_clk);
      #1;
   endtask

   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   initial begin
      run(8);
      sys_rst = 1'b0;
      rd(sut_pkg::ADDR_CTRL, sut_pkg::CTRL_RESET);
      rd(sut_pkg::ADDR_KEY, 8'h00);
      rd(8'h10, 8'h00);
      wr(sut_pkg::ADDR_CTRL, 8'hff);
      rd(sut_pkg::ADDR_CTRL, 8'hf8);
      wr(sut_pkg::ADDR_CTRL, 8'h00);
      $display("test registers done");
      wr(sut_pkg::ADDR_CTRL, 8'he0);
      wr(sut_pkg::ADDR_KEY, sut_pkg::KEY_SOFT_1);
      wr(sut_pkg::ADDR_KEY, sut_pkg::KEY_SOFT_2);
      pulse(8'h07);
      rd(sut_pkg::ADDR_CTRL, 8'h04);
      wr(sut_pkg::ADDR_CTRL, 8'h04);
      rd(sut_pkg::ADDR_CTRL, 8'h04);
      wr(sut_pkg::ADDR_CTRL, 8'h00);
      rd(sut_pkg::ADDR_CTRL, 8'h00);
      $display("test soft reset done");
      for (int i = 0; i < 6; i++) begin
         // last pass drives the pin low to prove it follows polarity
         reset_pin_polarity = (i != 5);
         if (i == 4) wr(sut_pkg::ADDR_KEY, sut_pkg::KEY_RUN_1);
         if (i == 5) wr(sut_pkg::ADDR_KEY, sut_pkg::KEY_SOFT_1);
         wr(sut_pkg::ADDR_KEY, (i < 4) ? bad_keys[i] : bad_keys[6 - i]);
         pulse((i == 5) ? 8'h03 : 8'h07);
         rd(sut_pkg::ADDR_CTRL, 8'h06);
         wr(sut_pkg::ADDR_CTRL, 8'h00);
      end
      reset_pin_polarity = 1'b1;
      $display("test wrong keys done");
      wr(sut_pkg::ADDR_KEY, sut_pkg::KEY_RUN_1);
      rd(sut_pkg::ADDR_CTRL, 8'h00);
      wr(sut_pkg::ADDR_KEY, sut_pkg::KEY_RUN_2);
      rd(sut_pkg::ADDR_CTRL, 8'h01);
      wr(sut_pkg::ADDR_KEY, sut_pkg::KEY_RUN_1);
      wr(sut_pkg::ADDR_CTRL, 8'h00);
      rd(sut_pkg::ADDR_CTRL, 8'h01);
      wr(sut_pkg::ADDR_KEY, sut_pkg::KEY_RUN_2);
      pulse(8'h07);
      rd(sut_pkg::ADDR_CTRL, 8'h06);
      wr(sut_pkg::ADDR_CTRL, 8'h00);
      $display("test key pairing done");
      wr(sut_pkg::ADDR_KEY, sut_pkg::KEY_RUN_1);
      wr(sut_pkg::ADDR_KEY, sut_pkg::KEY_RUN_2);
      run(4000);
      wr(sut_pkg::ADDR_KEY, sut_pkg::KEY_RUN_1);
      wr(sut_pkg::ADDR_KEY, sut_pkg::KEY_RUN_2);
      wait_rst(16383, 16386);
      chk({6'h00, rst_pin_oe, cpu_reset}, 8'h03);
      run(1);
      rd(sut_pkg::ADDR_CTRL, 8'h02);
      $display("test feed and time-out done");
      wr(sut_pkg::ADDR_CTRL, 8'h08);
      system_timer_prescale = 4'h1;
      idle_mode = 1'b1;
      wr(sut_pkg::ADDR_KEY, sut_pkg::KEY_RUN_1);
      wr(sut_pkg::ADDR_KEY, sut_pkg::KEY_RUN_2);
      wait_rst(32767, 32770);
      chk({6'h00, rst_pin_oe, cpu_reset}, 8'h01);
      idle_mode = 1'b0;
      system_timer_prescale = 4'h0;
      $display("test stretch done");
      // period code 1 here, so the time-out doubles to 32768 counted cycles
      wr(sut_pkg::ADDR_CTRL, 8'h30);
      wr(sut_pkg::ADDR_KEY, sut_pkg::KEY_RUN_1);
      wr(sut_pkg::ADDR_KEY, sut_pkg::KEY_RUN_2);
      run(1000);
      idle_mode = 1'b1;
      run(1000);
      idle_mode = 1'b0;
      power_down = 1'b1;
      run(1000);
      power_down = 1'b0;
      wait_rst(31767, 31770);
      $display("test idle and power-down done");
      stop_test();
   end
endmodule
